//--- rtl/fdog_freq_nco.sv
// Phase accumulator square wave generator
`timescale 1ns/1ps
`default_nettype none
module fdog_freq_nco (
  input  wire logic        clk_in,   // System clock
  input  wire logic        rst_in,   // Async reset, high
  input  wire logic [31:0] freq_in,  // Frequency in Hz
  output logic             wave_out  // Square wave
);
  // ****************************************************************
  // Accumulator
  // ****************************************************************
  // Step is freq * 2^32 / clk; computed as freq*43 (approx 42.95) trade-off
  localparam logic [7:0] STEP_MUL = 8'h2b;
  logic [31:0] acc;
  logic [31:0] next_acc;
  always_comb begin
    next_acc = acc + 32'(freq_in * 32'(STEP_MUL));
  end
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      acc <= 32'h0;
    end else begin
      acc <= next_acc;
    end
  end
  assign wave_out = acc[31];
endmodule // fdog_freq_nco
`default_nettype wire

//--- rtl/fdog_top.sv
// Flow digital output channel: pulse, frequency and alarm modes
//
// Strobed register access and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module fdog_top (
  input  wire logic        CLK_IN,       // 100 MHz clock
  input  wire logic        RST_IN,       // Async reset, high
  input  wire logic [3:0]  ADDR_IN,      // Register index
  input  wire logic [31:0] WDATA_IN,     // Write data
  input  wire logic        WR_IN,        // Write strobe
  input  wire logic        RD_IN,        // Read strobe
  output logic      [31:0] RDATA_OUT,    // Read data, one cycle later
  input  wire logic [31:0] TOTAL_IN,     // Selected totalizer value
  input  wire logic [31:0] VEL_IN,       // Velocity
  input  wire logic [31:0] AVOL_IN,      // Actual volumetric flow
  input  wire logic [31:0] SVOL_IN,      // Standard volumetric flow
  input  wire logic [31:0] MASS_IN,      // Mass flow
  input  wire logic        MEAS_ERR_IN,  // Measurement error flag
  input  wire logic        SYS_FAULT_IN, // System fault flag
  output logic             DOUT_OUT      // Digital output / contact closed
);
  default clocking chk_cb @(posedge CLK_IN);
  endclocking
  default disable iff (RST_IN);
  // ****************************************************************
  // Registers
  // ****************************************************************
  logic [31:0] ctrl, pulse_q, pulse_t, base_v, full_v, full_f, err_f;
  logic [31:0] alarm_v, test;
  logic [31:0] rdata, next_rdata;
  logic [31:0] cur_f;
  logic        dout, next_dout;
  logic [1:0]  mode_bits;
  assign mode_bits = ctrl[fdog_pkg::CTRL_MODE_LSB +: 2];

  function automatic logic hit(input logic [3:0] a, input logic [3:0] r);
    hit = (a == r);
  endfunction

  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      ctrl    <= fdog_pkg::RESET_WORD;
      pulse_q <= fdog_pkg::RESET_WORD;
      pulse_t <= fdog_pkg::RESET_WORD;
      base_v  <= fdog_pkg::RESET_WORD;
      full_v  <= fdog_pkg::RESET_WORD;
      full_f  <= fdog_pkg::RESET_WORD;
      err_f   <= fdog_pkg::RESET_WORD;
      alarm_v <= fdog_pkg::RESET_WORD;
      test    <= fdog_pkg::RESET_WORD;
    end else if (WR_IN) begin
      if (hit(ADDR_IN, fdog_pkg::ADDR_CTRL)) begin
        ctrl <= WDATA_IN;
      end else if (hit(ADDR_IN, fdog_pkg::ADDR_PULSE_Q)) begin
        pulse_q <= WDATA_IN;
      end else if (hit(ADDR_IN, fdog_pkg::ADDR_PULSE_T)) begin
        pulse_t <= WDATA_IN;
      end else if (hit(ADDR_IN, fdog_pkg::ADDR_BASE)) begin
        base_v <= WDATA_IN;
      end else if (hit(ADDR_IN, fdog_pkg::ADDR_FULL)) begin
        full_v <= WDATA_IN;
      end else if (hit(ADDR_IN, fdog_pkg::ADDR_FULL_F)) begin
        full_f <= WDATA_IN;
      end else if (hit(ADDR_IN, fdog_pkg::ADDR_ERR_F)) begin
        err_f <= WDATA_IN;
      end else if (hit(ADDR_IN, fdog_pkg::ADDR_ALARM_V)) begin
        alarm_v <= WDATA_IN;
      end else if (hit(ADDR_IN, fdog_pkg::ADDR_TEST)) begin
        test <= WDATA_IN;
      end
    end
  end

  // ****************************************************************
  // Measurement select
  // ****************************************************************
  logic [31:0] meas;
  always_comb begin
    case (ctrl[fdog_pkg::CTRL_SRC_LSB +: 2])
      2'h0:    meas = VEL_IN;
      2'h1:    meas = AVOL_IN;
      2'h2:    meas = SVOL_IN;
      default: meas = MASS_IN;
    endcase
  end

  // ****************************************************************
  // Frequency computation
  // ****************************************************************
  logic [31:0] lin_f, sel_f, hold_f, next_hold_f, span, ofs;
  logic [63:0] prod;
  always_comb begin
    span = full_v - base_v;
    ofs  = (meas <= base_v) ? 32'h0 : meas - base_v;
    prod = 64'(ofs) * 64'(full_f);
    if (span == 32'h0) begin
      lin_f = 32'h0;
    end else begin
      // Not clamped above full value, so over-range stays proportional
      lin_f = 32'(prod / 64'(span));
    end
  end
  always_comb begin
    next_hold_f = MEAS_ERR_IN ? hold_f : lin_f;
    sel_f = lin_f;
    if (test[fdog_pkg::TEST_FREQ_BIT]) begin
      sel_f = {16'h0, test[fdog_pkg::TEST_VAL_LSB +: 16]};
    end else if (MEAS_ERR_IN) begin
      case (ctrl[fdog_pkg::CTRL_FERR_LSB +: 2])
        2'h0:    sel_f = hold_f;
        2'h1:    sel_f = 32'h0;
        2'h2:    sel_f = full_f;
        default: sel_f = err_f;
      endcase
    end
  end
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      hold_f <= 32'h0;
      cur_f  <= 32'h0;
    end else begin
      hold_f <= next_hold_f;
      cur_f  <= sel_f;
    end
  end
  logic wave;
  fdog_freq_nco u_nco (
    .clk_in   (CLK_IN),
    .rst_in   (RST_IN),
    .freq_in  (cur_f),
    .wave_out (wave)
  );

  // ****************************************************************
  // Pulse totalizer
  // ****************************************************************
  logic [31:0] last_tot, next_last_tot, owed, next_owed;
  logic [31:0] wcnt, next_wcnt;
  logic [15:0] tcnt, next_tcnt;
  logic        ptest_d, next_ptest_d, pulse, next_pulse;
  logic [31:0] gap, next_gap, gap_cnt, next_gap_cnt;
  logic        stop_err, new_test;
  assign stop_err = MEAS_ERR_IN && ctrl[fdog_pkg::CTRL_PERR_BIT];
  assign new_test = test[fdog_pkg::TEST_PULSE_BIT] && !ptest_d;
  always_comb begin
    next_last_tot = last_tot;
    next_owed     = owed;
    next_wcnt     = wcnt;
    next_tcnt     = tcnt;
    next_pulse    = pulse;
    next_gap      = gap;
    next_gap_cnt  = gap_cnt + 32'h1;
    next_ptest_d  = test[fdog_pkg::TEST_PULSE_BIT];
    // One pulse owed per quantity of growth
    if (pulse_q != 32'h0 && TOTAL_IN - last_tot >= pulse_q &&
        !MEAS_ERR_IN) begin
      next_last_tot = last_tot + pulse_q;
      next_owed     = owed + 32'h1;
      next_gap      = gap_cnt;
      next_gap_cnt  = 32'h0;
    end
    // Hold repeats pulses at last valid spacing
    if (MEAS_ERR_IN && !ctrl[fdog_pkg::CTRL_PERR_BIT] && gap != 32'h0 &&
        gap_cnt >= gap) begin
      next_owed    = owed + 32'h1;
      next_gap_cnt = 32'h0;
    end
    if (new_test) begin
      next_tcnt = test[fdog_pkg::TEST_VAL_LSB +: 16];
    end
    // Pulse high and low each pulse-time plus one clock long
    if (wcnt != 32'h0) begin
      next_wcnt = wcnt - 32'h1;
    end else if (pulse) begin
      next_pulse = 1'b0;
      next_wcnt  = 32'(pulse_t * fdog_pkg::PT_UNIT_CYC);
    end else if (test[fdog_pkg::TEST_PULSE_BIT]) begin
      if (tcnt != 16'h0 && !new_test) begin
        next_tcnt  = tcnt - 16'h1;
        next_pulse = 1'b1;
        next_wcnt  = 32'(pulse_t * fdog_pkg::PT_UNIT_CYC);
      end
    end else if (owed != 32'h0 && !stop_err) begin
      next_owed  = next_owed - 32'h1;
      next_pulse = 1'b1;
      next_wcnt  = 32'(pulse_t * fdog_pkg::PT_UNIT_CYC);
    end
    if (stop_err) begin
      next_owed = 32'h0;
    end
    if (mode_bits != 2'(fdog_pkg::FDOG_PULSE)) begin
      next_owed     = 32'h0;
      next_last_tot = TOTAL_IN;
    end
  end
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      last_tot <= 32'h0;
      owed     <= 32'h0;
      wcnt     <= 32'h0;
      tcnt     <= 16'h0;
      pulse    <= 1'b0;
      ptest_d  <= 1'b0;
      gap      <= 32'h0;
      gap_cnt  <= 32'h0;
    end else begin
      last_tot <= next_last_tot;
      owed     <= next_owed;
      wcnt     <= next_wcnt;
      tcnt     <= next_tcnt;
      pulse    <= next_pulse;
      ptest_d  <= next_ptest_d;
      gap      <= next_gap;
      gap_cnt  <= next_gap_cnt;
    end
  end

  // ****************************************************************
  // Alarm
  // ****************************************************************
  logic trip, active;
  always_comb begin
    case (ctrl[fdog_pkg::CTRL_ATYPE_LSB +: 2])
      2'h0:    trip = meas <= alarm_v;
      2'h1:    trip = meas >= alarm_v;
      default: trip = SYS_FAULT_IN;
    endcase
    active = test[fdog_pkg::TEST_ALARM_BIT] ?
             test[fdog_pkg::TEST_ALON_BIT] : trip;
  end

  // ****************************************************************
  // Output and read mux
  // ****************************************************************
  always_comb begin
    case (mode_bits)
      2'h1:    next_dout = pulse;
      2'h2:    next_dout = wave;
      2'h3:    next_dout = active ^ ctrl[fdog_pkg::CTRL_AFS_BIT];
      default: next_dout = 1'b0;
    endcase
    next_rdata = 32'h0;
    if (RD_IN) begin
      if (hit(ADDR_IN, fdog_pkg::ADDR_CTRL)) begin
        next_rdata = ctrl;
      end else if (hit(ADDR_IN, fdog_pkg::ADDR_PULSE_Q)) begin
        next_rdata = pulse_q;
      end else if (hit(ADDR_IN, fdog_pkg::ADDR_PULSE_T)) begin
        next_rdata = pulse_t;
      end else if (hit(ADDR_IN, fdog_pkg::ADDR_BASE)) begin
        next_rdata = base_v;
      end else if (hit(ADDR_IN, fdog_pkg::ADDR_FULL)) begin
        next_rdata = full_v;
      end else if (hit(ADDR_IN, fdog_pkg::ADDR_FULL_F)) begin
        next_rdata = full_f;
      end else if (hit(ADDR_IN, fdog_pkg::ADDR_ERR_F)) begin
        next_rdata = err_f;
      end else if (hit(ADDR_IN, fdog_pkg::ADDR_ALARM_V)) begin
        next_rdata = alarm_v;
      end else if (hit(ADDR_IN, fdog_pkg::ADDR_TEST)) begin
        next_rdata = test;
      end else if (hit(ADDR_IN, fdog_pkg::ADDR_STATUS)) begin
        next_rdata = {16'h0, tcnt[7:0], 4'h0, trip, pulse,
                      MEAS_ERR_IN, SYS_FAULT_IN};
      end else if (hit(ADDR_IN, fdog_pkg::ADDR_CUR_F)) begin
        next_rdata = cur_f;
      end
    end
  end
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      dout  <= 1'b0;
      rdata <= 32'h0;
    end else begin
      dout  <= next_dout;
      rdata <= next_rdata;
    end
  end
  assign DOUT_OUT  = dout;
  assign RDATA_OUT = rdata;

  // ****************************************************************
  // Checks
  // ****************************************************************
  // Counter instead of a long repetition, which the tools would unroll
  logic [31:0] high_run;
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      high_run <= 32'h0;
    end else begin
      high_run <= pulse ? high_run + 32'h1 : 32'h0;
    end
  end
  sequence err_on_s;
    MEAS_ERR_IN && ctrl[fdog_pkg::CTRL_PERR_BIT];
  endsequence
  sequence pulse_end_s;
    pulse ##1 !pulse;
  endsequence
  stop_no_pulse_a: assert property (
    err_on_s ##1 err_on_s |-> !next_pulse || test[0] || pulse)
    else $error("pulse started during stop error");
  low_err_f_a: assert property (
    MEAS_ERR_IN && !test[1] && ctrl[6:5] == 2'h1 |=> cur_f == 32'h0)
    else $error("low error frequency not zero");
  user_err_f_a: assert property (
    MEAS_ERR_IN && !test[1] && ctrl[6:5] == 2'h3 |=> cur_f == $past(err_f))
    else $error("user error frequency wrong");
  test_f_a: assert property (
    test[1] |=> cur_f == {16'h0, $past(test[31:16])})
    else $error("test frequency wrong");
  base_zero_a: assert property (
    !MEAS_ERR_IN && !test[1] && meas == base_v |=> cur_f == 32'h0)
    else $error("base value not zero frequency");
  full_map_a: assert property (
    !MEAS_ERR_IN && !test[1] && meas == full_v && full_v > base_v
    |=> cur_f == $past(full_f))
    else $error("full value not full frequency");
  alarm_pol_a: assert property (
    mode_bits == 2'h3 |=> dout == $past(active ^ ctrl[7]))
    else $error("alarm contact polarity wrong");
  off_low_a: assert property (
    mode_bits == 2'h0 |=> !dout)
    else $error("disabled output not low");
  fault_type_a: assert property (
    ctrl[9:8] == 2'h2 && !test[2] |-> active == SYS_FAULT_IN)
    else $error("fault alarm follows measurement");
  pulse_width_a: assert property (
    pulse_end_s |-> high_run == 32'(pulse_t * fdog_pkg::PT_UNIT_CYC) + 32'h1)
    else $error("pulse width wrong");
endmodule // fdog_top
`default_nettype wire

//--- shared/fdog_pkg.sv
// Constants and types for the flow digital output generator
package fdog_pkg;
  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [3:0] ADDR_CTRL     = 4'h0;
  localparam logic [3:0] ADDR_PULSE_Q  = 4'h1;
  localparam logic [3:0] ADDR_PULSE_T  = 4'h2;
  localparam logic [3:0] ADDR_BASE     = 4'h3;
  localparam logic [3:0] ADDR_FULL     = 4'h4;
  localparam logic [3:0] ADDR_FULL_F   = 4'h5;
  localparam logic [3:0] ADDR_ERR_F    = 4'h6;
  localparam logic [3:0] ADDR_ALARM_V  = 4'h7;
  localparam logic [3:0] ADDR_TEST     = 4'h8;
  localparam logic [3:0] ADDR_STATUS   = 4'h9;
  localparam logic [3:0] ADDR_CUR_F    = 4'ha;
  // CTRL fields
  localparam int CTRL_MODE_LSB   = 0;
  localparam int CTRL_SRC_LSB    = 2;
  localparam int CTRL_PERR_BIT   = 4;
  localparam int CTRL_FERR_LSB   = 5;
  localparam int CTRL_AFS_BIT    = 7;
  localparam int CTRL_ATYPE_LSB  = 8;
  // TEST fields
  localparam int TEST_PULSE_BIT  = 0;
  localparam int TEST_FREQ_BIT   = 1;
  localparam int TEST_ALARM_BIT  = 2;
  localparam int TEST_ALON_BIT   = 3;
  localparam int TEST_VAL_LSB    = 16;
  localparam logic [31:0] RESET_WORD = 32'h0000_0000;
  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_HZ          = 100_000_000;
  localparam int PT_UNIT_US      = 1;
  localparam int PT_UNIT_CYC     = CLK_HZ / 1_000_000 * PT_UNIT_US;
  localparam int FREQ_ACC_W      = 32;
  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [1:0] {FDOG_OFF, FDOG_PULSE, FDOG_FREQ, FDOG_ALARM}
    fdog_mode_t;
  typedef enum logic [1:0] {FDOG_FE_HOLD, FDOG_FE_LOW, FDOG_FE_HIGH,
    FDOG_FE_OTHER} fdog_ferr_t;
  typedef enum logic [1:0] {FDOG_AT_LOW, FDOG_AT_HIGH, FDOG_AT_FAULT}
    fdog_atype_t;
endpackage

//--- sim/fdog_counter.sv
// Far-side counter model: tallies pulses and measures their high time
`timescale 1ns/1ps
`default_nettype none
module fdog_counter (
  input  wire logic        clk_in,    // Sampling clock
  input  wire logic        rst_in,    // Async reset, high
  input  wire logic        clear_in,  // Zero the edge tally
  input  wire logic        line_in,   // Output line under watch
  output logic      [15:0] edges_out, // Rising edges seen
  output logic      [15:0] width_out  // Last high time in cycles
);
  logic        last;
  logic [15:0] run;
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      last      <= 1'h0;
      run       <= 16'h0;
      edges_out <= 16'h0;
      width_out <= 16'h0;
    end else begin
      last <= line_in;
      if (clear_in) begin
        edges_out <= 16'h0;
      end else if (line_in && !last) begin
        edges_out <= edges_out + 16'h1;
      end
      if (line_in) begin
        run <= run + 16'h1;
      end else if (last) begin
        width_out <= run;
        run       <= 16'h0;
      end
    end
  end
endmodule // fdog_counter
`default_nettype wire

//--- sim/tb.sv
// Self-checking bench for the flow digital output channel
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam int LIMIT = 50000;
  localparam logic [1:0]  AT[9] = '{2'h0, 2'h0, 2'h1, 2'h1, 2'h2, 2'h2,
                                    2'h0, 2'h0, 2'h2};
  localparam logic        FS[9] = '{1'h0, 1'h0, 1'h0, 1'h0, 1'h0, 1'h0,
                                    1'h1, 1'h1, 1'h1};
  localparam logic        FT[9] = '{1'h0, 1'h0, 1'h0, 1'h0, 1'h1, 1'h0,
                                    1'h0, 1'h0, 1'h1};
  localparam logic        EX[9] = '{1'h1, 1'h0, 1'h1, 1'h0, 1'h1, 1'h0,
                                    1'h0, 1'h1, 1'h0};
  localparam logic [31:0] VV[9] = '{32'h64, 32'h65, 32'h64, 32'h63, 32'h0,
                                    32'h0, 32'h64, 32'h65, 32'h0};
  localparam logic [31:0] SF[4] = '{32'h0, 32'h3e8, 32'h1f4, 32'hfa};
  localparam logic [31:0] EF[4] = '{32'h1f4, 32'h0, 32'h3e8, 32'h7d0};
  logic        clk, rst, wr, rd, meas_err, sys_fault, dout, clr;
  logic [3:0]  addr;
  logic [31:0] wdata, rdata, total, vel, avol, svol, mass, d;
  logic [15:0] edges, width;
  int          err_count, samples_checked, cycles;

  fdog_top fdog_top_inst (.CLK_IN(clk), .RST_IN(rst), .ADDR_IN(addr),
    .WDATA_IN(wdata), .WR_IN(wr), .RD_IN(rd), .RDATA_OUT(rdata),
    .TOTAL_IN(total), .VEL_IN(vel), .AVOL_IN(avol), .SVOL_IN(svol),
    .MASS_IN(mass), .MEAS_ERR_IN(meas_err), .SYS_FAULT_IN(sys_fault),
    .DOUT_OUT(dout));
  fdog_counter fdog_counter_inst (.clk_in(clk), .rst_in(rst),
    .clear_in(clr), .line_in(dout), .edges_out(edges), .width_out(width));

  always #5 clk = ~clk;
  // Hang guard
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      err_count++;
      $display("MISMATCH t=%0t run did not finish", $time);
      print_verdict();
    end
  end

  // ****************************************************************
  // Bus and check tasks
  // ****************************************************************
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic wreg(input logic [3:0] a, input logic [31:0] v);
    @(posedge clk);
    wr <= 1'h1;
    addr <= a;
    wdata <= v;
    @(posedge clk);
    wr <= 1'h0;
  endtask
  // Read data stands only in the cycle after the strobe; taken at its end
  task automatic rreg(input logic [3:0] a, output logic [31:0] v);
    @(posedge clk);
    rd <= 1'h1;
    addr <= a;
    @(posedge clk);
    rd <= 1'h0;
    @(posedge clk);
    v = rdata;
  endtask
  task automatic chk(input logic [31:0] g, e, input string m);
    samples_checked++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, m, g, e);
    end
  endtask
  task automatic rng(input logic [15:0] g, input int lo, hi, input string m);
    samples_checked++;
    if ($isunknown(g) || g < lo || g > hi) begin
      err_count++;
      $display("MISMATCH t=%0t %s got %0d", $time, m, g);
    end
  endtask
  // Bounded poll hides the one-cycle latency of cur_f
  task automatic poll(input logic [3:0] a, input logic [31:0] e,
                      input string m);
    int n;
    n = 0;
    rreg(a, d);
    while (d !== e && n < 64) begin
      rreg(a, d);
      n++;
    end
    chk(d, e, m);
  endtask
  function automatic logic [31:0] cw(input logic [1:0] md, sr, fe, at,
                                     input logic pe, fs);
    cw = 32'h0;
    cw[fdog_pkg::CTRL_MODE_LSB +: 2]  = md;
    cw[fdog_pkg::CTRL_SRC_LSB +: 2]   = sr;
    cw[fdog_pkg::CTRL_PERR_BIT]       = pe;
    cw[fdog_pkg::CTRL_FERR_LSB +: 2]  = fe;
    cw[fdog_pkg::CTRL_AFS_BIT]        = fs;
    cw[fdog_pkg::CTRL_ATYPE_LSB +: 2] = at;
  endfunction
  function automatic logic [31:0] tw(input int b, input logic [15:0] v);
    tw = 32'h0;
    tw[b] = 1'h1;
    tw[fdog_pkg::TEST_VAL_LSB +: 16] = v;
  endfunction
  task automatic clear();
    @(posedge clk);
    clr <= 1'h1;
    @(posedge clk);
    clr <= 1'h0;
  endtask

  // ****************************************************************
  // Tests
  // ****************************************************************
  initial begin
    clk = 1'h0;
    rst = 1'h1;
    wr = 1'h0;
    rd = 1'h0;
    clr = 1'h0;
    addr = 4'h0;
    wdata = 32'h0;
    total = 32'h0;
    vel = 32'h64;
    avol = 32'h44c;
    svol = 32'h258;
    mass = 32'h15e;
    meas_err = 1'h0;
    sys_fault = 1'h0;
    err_count = 0;
    samples_checked = 0;
    cycles = 0;
    cyc(2);
    rst <= 1'h0;
    rreg(fdog_pkg::ADDR_CTRL, d);
    chk(d, 32'h0, "ctrl after reset");
    rreg(4'hf, d);
    chk(d, 32'h0, "unmapped read");
    chk({31'h0, dout}, 32'h0, "off mode output");
    $display("reset test done");
    // Frequency mapping per source
    wreg(fdog_pkg::ADDR_BASE, 32'h64);
    wreg(fdog_pkg::ADDR_FULL, 32'h44c);
    wreg(fdog_pkg::ADDR_FULL_F, 32'h3e8);
    wreg(fdog_pkg::ADDR_ERR_F, 32'h7d0);
    for (int s = 0; s < 4; s++) begin
      wreg(fdog_pkg::ADDR_CTRL, cw(fdog_pkg::FDOG_FREQ, s[1:0], 2'h0,
           2'h0, 1'h0, 1'h0));
      poll(fdog_pkg::ADDR_CUR_F, SF[s], "source freq");
    end
    for (int f = 0; f < 4; f++) begin
      wreg(fdog_pkg::ADDR_CTRL, cw(fdog_pkg::FDOG_FREQ, 2'h2, f[1:0],
           2'h0, 1'h0, 1'h0));
      poll(fdog_pkg::ADDR_CUR_F, 32'h1f4, "frequency before error");
      meas_err <= 1'h1;
      svol <= 32'h44c;
      poll(fdog_pkg::ADDR_CUR_F, EF[f], "error response");
      meas_err <= 1'h0;
      svol <= 32'h258;
    end
    wreg(fdog_pkg::ADDR_TEST, tw(fdog_pkg::TEST_FREQ_BIT, 16'hc350));
    clear();
    cyc(20000);
    rng(edges, 9, 11, "test frequency edges");
    wreg(fdog_pkg::ADDR_TEST, 32'h0);
    $display("frequency test done");
    // Pulse mode
    wreg(fdog_pkg::ADDR_PULSE_Q, 32'ha);
    wreg(fdog_pkg::ADDR_PULSE_T, 32'h1);
    wreg(fdog_pkg::ADDR_CTRL, cw(fdog_pkg::FDOG_PULSE, 2'h0, 2'h0, 2'h0,
         1'h0, 1'h0));
    clear();
    total <= 32'h1e;
    cyc(1500);
    chk({16'h0, edges}, 32'h3, "pulses per quantity");
    rng(width, 100, 101, "pulse width");
    wreg(fdog_pkg::ADDR_CTRL, cw(fdog_pkg::FDOG_PULSE, 2'h0, 2'h0, 2'h0,
         1'h1, 1'h0));
    meas_err <= 1'h1;
    clear();
    total <= 32'h3c;
    cyc(1500);
    chk({16'h0, edges}, 32'h0, "stop on error");
    meas_err <= 1'h0;
    wreg(fdog_pkg::ADDR_CTRL, cw(fdog_pkg::FDOG_PULSE, 2'h0, 2'h0, 2'h0,
         1'h0, 1'h0));
    repeat (4) begin
      total <= total + 32'ha;
      cyc(500);
    end
    meas_err <= 1'h1;
    clear();
    cyc(2000);
    rng(edges, 2, 8, "hold on error");
    meas_err <= 1'h0;
    cyc(600);
    clear();
    wreg(fdog_pkg::ADDR_TEST, tw(fdog_pkg::TEST_PULSE_BIT, 16'h5));
    cyc(3000);
    chk({16'h0, edges}, 32'h5, "test pulse count");
    wreg(fdog_pkg::ADDR_TEST, 32'h0);
    $display("pulse test done");
    // Alarm table
    wreg(fdog_pkg::ADDR_ALARM_V, 32'h64);
    for (int i = 0; i < 9; i++) begin
      wreg(fdog_pkg::ADDR_CTRL, cw(fdog_pkg::FDOG_ALARM, 2'h0, 2'h0, AT[i],
           1'h0, FS[i]));
      vel <= VV[i];
      sys_fault <= FT[i];
      cyc(4);
      chk({31'h0, dout}, {31'h0, EX[i]}, "alarm");
    end
    sys_fault <= 1'h0;
    wreg(fdog_pkg::ADDR_CTRL, cw(fdog_pkg::FDOG_ALARM, 2'h0, 2'h0, 2'h0,
         1'h0, 1'h0));
    vel <= 32'h65;
    wreg(fdog_pkg::ADDR_TEST, 32'hc);
    cyc(3);
    chk({31'h0, dout}, 32'h1, "alarm test on");
    vel <= 32'h64;
    wreg(fdog_pkg::ADDR_TEST, 32'h4);
    cyc(3);
    chk({31'h0, dout}, 32'h0, "alarm test off");
    wreg(fdog_pkg::ADDR_TEST, 32'h0);
    cyc(3);
    chk({31'h0, dout}, 32'h1, "alarm released");
    rreg(fdog_pkg::ADDR_STATUS, d);
    chk(d, 32'h8, "status with low trip");
    wreg(fdog_pkg::ADDR_CTRL, 32'h0);
    cyc(3);
    chk({31'h0, dout}, 32'h0, "back to off");
    $display("alarm test done");
    print_verdict();
  end
endmodule // tb
`default_nettype wire
